//--- verilog/asram_pkg.sv
// constants for the static ram host controller
// What this block does
// - write: chip select and strobe low
// - read: select, drive enable low, strobe high
// - write lasts while select and strobe overlap
// - write data stable around terminating edge
// - host never drives while device drives
package asram_pkg;
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CLK_PS = 8000;
  // access time, write pulse, data set-up, float time in ps
  localparam int unsigned T_AA_PS   = 12000;
  localparam int unsigned T_PWE_PS  = 8000;
  localparam int unsigned T_SD_PS   = 6000;
  localparam int unsigned T_HZ_PS   = 6000;
  localparam int unsigned RD_CYC  = (T_AA_PS + CLK_PS - 1) / CLK_PS + 1;
  localparam int unsigned WR_CYC  = (T_PWE_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned SD_CYC  = (T_SD_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned HZ_CYC  = (T_HZ_PS + CLK_PS - 1) / CLK_PS;
  localparam logic [3:0] RD_CNT = 4'(RD_CYC);
  localparam logic [3:0] WR_CNT = 4'(WR_CYC > SD_CYC ? WR_CYC : SD_CYC);
  localparam logic [3:0] HZ_CNT = 4'(HZ_CYC);
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_READ  = 5'h02,
    ST_WRITE = 5'h04,
    ST_WHOLD = 5'h08,
    ST_FLOAT = 5'h10
  } asram_state_t;
endpackage : asram_pkg

//--- verilog/asram_host.sv
// host controller driving an asynchronous byte-wide static ram
module asram_host (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  // user request
  input  wire logic                        req_valid,
  input  wire logic                        req_write,
  input  wire logic [asram_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [asram_pkg::DATA_W-1:0] req_wdata,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic [asram_pkg::DATA_W-1:0]     rsp_rdata,
  // memory pins
  output logic                             chip_sel_n,
  output logic                             out_en_n,
  output logic                             wr_strobe_n,
  output logic [asram_pkg::ADDR_W-1:0]     location_lines,
  output logic [asram_pkg::DATA_W-1:0]     byte_lines_wr,
  output logic                             byte_lines_drive,
  input  wire logic [asram_pkg::DATA_W-1:0] byte_lines_rd
);
  asram_pkg::asram_state_t st_q, st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] cnt_dec;
  logic       cnt_zero;
  logic       take;
  // transfer events decoded from state and request
  logic       wr_take;
  logic       rd_take;
  logic       wr_end;
  logic       wr_done;
  logic       rd_done;
  logic       idle_next;

  // pin and response registers
  logic                         chip_sel_n_q;
  logic                         chip_sel_n_d;
  logic                         out_en_n_q;
  logic                         out_en_n_d;
  logic                         wr_strobe_n_q;
  logic                         wr_strobe_n_d;
  logic [asram_pkg::ADDR_W-1:0] location_q;
  logic [asram_pkg::ADDR_W-1:0] location_d;
  logic [asram_pkg::DATA_W-1:0] byte_wr_q;
  logic [asram_pkg::DATA_W-1:0] byte_wr_d;
  logic                         byte_drive_q;
  logic                         byte_drive_d;
  logic                         ready_q;
  logic                         ready_d;
  logic                         rsp_valid_q;
  logic                         rsp_valid_d;
  logic [asram_pkg::DATA_W-1:0] rsp_rdata_q;
  logic [asram_pkg::DATA_W-1:0] rsp_rdata_d;

  assign cnt_zero = (cnt_q == 4'h0);
  assign cnt_dec  = cnt_zero ? 4'h0 : cnt_q - 4'h1;
  assign take     = req_valid && req_ready;

  // sequencer: read wait, write pulse, float gap
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_dec;
    unique case (st_q)
      asram_pkg::ST_IDLE: begin
        if (take) begin
          st_d  = req_write ? asram_pkg::ST_WRITE : asram_pkg::ST_READ;
          cnt_d = req_write ? asram_pkg::WR_CNT : asram_pkg::RD_CNT;
        end
      end
      asram_pkg::ST_READ: begin
        if (cnt_zero) begin
          st_d  = asram_pkg::ST_FLOAT;
          cnt_d = asram_pkg::HZ_CNT;
        end
      end
      asram_pkg::ST_WRITE: begin
        if (cnt_zero) begin
          st_d = asram_pkg::ST_WHOLD;
        end
      end
      asram_pkg::ST_WHOLD: begin
        st_d = asram_pkg::ST_IDLE;
      end
      asram_pkg::ST_FLOAT: begin
        if (cnt_zero) begin
          st_d = asram_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= asram_pkg::ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign wr_take   = take && req_write;
  assign rd_take   = take && !req_write;
  assign wr_end    = (st_q == asram_pkg::ST_WRITE) && cnt_zero;
  assign wr_done   = (st_q == asram_pkg::ST_WHOLD);
  assign rd_done   = (st_q == asram_pkg::ST_READ) && cnt_zero;
  assign idle_next = (st_d == asram_pkg::ST_IDLE);

  // select high whenever idle gives standby
  assign chip_sel_n_d  = take                 ? 1'b0 :
                         (wr_done || rd_done) ? 1'b1 :
                         chip_sel_n_q;
  // drive enable stays high on writes so the device floats
  assign out_en_n_d    = rd_take              ? 1'b0 :
                         (wr_take || rd_done) ? 1'b1 :
                         out_en_n_q;
  // strobe rises a cycle before select and data go
  assign wr_strobe_n_d = wr_take              ? 1'b0 :
                         (rd_take || wr_end)  ? 1'b1 :
                         wr_strobe_n_q;
  assign location_d    = take ? req_addr : location_q;
  assign byte_wr_d     = wr_take ? req_wdata : byte_wr_q;
  // host lets go of the byte lines before any read
  assign byte_drive_d  = wr_take              ? 1'b1 :
                         (rd_take || wr_done) ? 1'b0 :
                         byte_drive_q;

  // read byte captured as the device is deselected
  assign ready_d       = idle_next && !take;
  assign rsp_valid_d   = rd_done;
  assign rsp_rdata_d   = rd_done ? byte_lines_rd : rsp_rdata_q;

  // one register per pin, reset to standby levels
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chip_sel_n_q <= 1'b1;
    end else begin
      chip_sel_n_q <= chip_sel_n_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      out_en_n_q <= 1'b1;
    end else begin
      out_en_n_q <= out_en_n_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_strobe_n_q <= 1'b1;
    end else begin
      wr_strobe_n_q <= wr_strobe_n_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      location_q <= '0;
    end else begin
      location_q <= location_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      byte_wr_q <= '0;
    end else begin
      byte_wr_q <= byte_wr_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      byte_drive_q <= 1'b0;
    end else begin
      byte_drive_q <= byte_drive_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= rsp_valid_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rsp_rdata_q <= '0;
    end else begin
      rsp_rdata_q <= rsp_rdata_d;
    end
  end

  // every output straight from its register
  assign chip_sel_n       = chip_sel_n_q;
  assign out_en_n         = out_en_n_q;
  assign wr_strobe_n      = wr_strobe_n_q;
  assign location_lines   = location_q;
  assign byte_lines_wr    = byte_wr_q;
  assign byte_lines_drive = byte_drive_q;
  assign req_ready        = ready_q;
  assign rsp_valid        = rsp_valid_q;
  assign rsp_rdata        = rsp_rdata_q;
endmodule : asram_host

//--- sim/asram_mem.sv
// behavioural static ram on the far side of the host
module asram_mem (
  // control pins from the host
  input  wire logic        cs_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  // location and byte lines
  input  wire logic [18:0] a,
  input  wire logic [7:0]  d,
  // read drive back to the bench
  output logic             drv,
  output logic [7:0]       q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:19'h7FFFF];
  logic       was = 1'b0;
  assign drv = !cs_n && !oe_n && we_n;
  assign q = mem[a];
  // store on whichever edge ends the overlap
  always @(cs_n, we_n) begin
    if (was && (cs_n || we_n)) mem[a] = d;
    was = !cs_n && !we_n;
  end
endmodule : asram_mem

//--- sim/asram_host_asserts.sv
// pin sequencing checks for the host controller
module asram_host_asserts (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // handshake
  input  wire logic       req_ready,
  input  wire logic       rsp_valid,
  // memory pins
  input  wire logic       chip_sel_n,
  input  wire logic       out_en_n,
  input  wire logic       wr_strobe_n,
  input  wire logic       byte_lines_drive,
  input  wire logic [7:0] byte_lines_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_wr_sel: assert property (!wr_strobe_n |-> !chip_sel_n && byte_lines_drive) else $error("ws");
  a_rdy_idle: assert property (req_ready |-> chip_sel_n && out_en_n && wr_strobe_n) else $error("ri");
  a_rd_strb: assert property (!out_en_n |-> wr_strobe_n && !chip_sel_n) else $error("rs");
  a_wr_float: assert property (!wr_strobe_n |-> out_en_n) else $error("wf");
  a_no_fight: assert property (!out_en_n |-> !byte_lines_drive) else $error("nf");
  a_rd_len: assert property ($fell(out_en_n) |-> !out_en_n [*4] ##1 out_en_n) else $error("rl");
  a_rd_rsp: assert property ($fell(out_en_n) |-> ##4 rsp_valid ##1 !rsp_valid) else $error("rr");
  a_wr_len: assert property ($fell(wr_strobe_n) |-> !wr_strobe_n [*2] ##1 wr_strobe_n) else $error("wl");
  a_wr_hold: assert property ($rose(wr_strobe_n) |-> !chip_sel_n && $stable(byte_lines_wr)) else $error("wh");
endmodule : asram_host_asserts
bind asram_host asram_host_asserts i_asram_host_asserts (.*);

//--- sim/tb_top.sv
// self-checking bench for the static ram host controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, nrst = 0, req_valid = 0, req_write = 0, req_ready, rsp_valid;
  logic cs_n, oe_n, we_n, oe, drv;
  logic [18:0] req_addr = 0, a;
  logic [7:0] req_wdata = 0, rd, bo, bi, q;
  int n_errors = 0, n_tests = 0, cyc = 0;
  assign bi = oe ? bo : drv ? q : ~bo;
  asram_host i_asram_host (.clk_sys, .nrst, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_ready, .rsp_valid, .rsp_rdata(rd), .chip_sel_n(cs_n), .out_en_n(oe_n),
    .wr_strobe_n(we_n), .location_lines(a), .byte_lines_wr(bo), .byte_lines_drive(oe),
    .byte_lines_rd(bi));
  asram_mem i_asram_mem (.cs_n, .oe_n, .we_n, .a, .d(bi), .drv, .q);
  initial forever #4 clk_sys = ~clk_sys;
  task automatic xfer(input logic w, input logic [18:0] ad, input logic [7:0] dt);
    @(negedge clk_sys);
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, ad, dt};
    while (req_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    req_valid = 0;
    if (!w) begin
      while (rsp_valid !== 1'b1) @(negedge clk_sys);
      n_tests++;
      if (rd !== dt) begin
        n_errors++;
        $display("[FAIL] %0t got %h exp %h", $time, rd, dt);
      end
    end
  endtask : xfer
  task automatic t_fill;
    xfer(1, 19'h00000, 8'h5A);
    xfer(1, 19'h7FFFF, 8'hC3);
    xfer(0, 19'h00000, 8'h5A);
    xfer(0, 19'h7FFFF, 8'hC3);
  endtask : t_fill
  task automatic t_keep;
    xfer(1, 19'h2AAAA, 8'h11);
    xfer(1, 19'h2AAAA, 8'hEE);
    xfer(0, 19'h2AAAA, 8'hEE);
    xfer(0, 19'h2AAAA, 8'hEE);
    xfer(0, 19'h00000, 8'h5A);
  endtask : t_keep
  task automatic t_reset;
    @(negedge clk_sys);
    nrst = 0;
    @(negedge clk_sys);
    n_tests++;
    if ({req_ready, rsp_valid, cs_n, oe_n, we_n, oe} !== 6'h0E) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, {req_ready, rsp_valid, cs_n, oe_n, we_n, oe}, 6'h0E);
    end
    nrst = 1;
    @(negedge clk_sys);
    n_tests++;
    if (req_ready !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, req_ready, 1'b1);
    end
    xfer(0, 19'h2AAAA, 8'hEE);
  endtask : t_reset
  task automatic conclude;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(negedge clk_sys);
    nrst = 1;
    t_fill();
    t_keep();
    t_reset();
    conclude();
  end
endmodule : tb_top
